// ---- fieldbus_reader_pkg.sv ----
// Constants of the fieldbus slave register reader.
// Assumes one 200 MHz clock and a 32-bit word register port.
//
// Functional notes
// R1: A read starts only on a rising edge of start; a held level never retriggers.
// R2: Length must be 1 to 4 bytes; otherwise error code 0x0F61.
// R3: Command code 1 is auto-increment read, 4 configured-address, 7 broadcast.
// R4: Any other command code raises error with code 0x0F62.
// R5: Position outside the range of the chosen command raises error code 0x0F60.
// R6: Broadcast read ignores the position and never range checks it.
// R7: Auto-increment positions are 0x0000, then 0xFFFF down to 0xFFDD.
// R8: Configured-address positions are 1001 to 1036.
// R9: Starting a read clears the value and working count to zero.
// R10: On done, the value shows the read data and the counter the final count.
// R11: Ring slaves bump the position field; the one seeing zero answers.
// R12: Only the slave whose station address matches the position answers.
// R13: Broadcast read returns the bitwise OR of all slaves' bytes.
// R14: Working count rises by one per slave that read successfully.
// R15: Done rises only after a slave really performed the read.
// R16: Busy stays high from acceptance until the command finishes.
// R17: Failures raise error and show the numeric cause on the code output.
// R18: Parameters are checked first; a failed check sends nothing and gives no done.
// R19: Busy falls in the same cycle that done or error rises.
package fieldbus_reader_pkg;
    // ------------
    // Register byte offsets
    // ------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_POS = 8'h04;
    localparam logic [7:0] OFF_OFS = 8'h08;
    localparam logic [7:0] OFF_LEN = 8'h0C;
    localparam logic [7:0] OFF_CMD = 8'h10;
    localparam logic [7:0] OFF_STAT = 8'h14;
    localparam logic [7:0] OFF_VALUE = 8'h18;
    localparam logic [7:0] OFF_WKC = 8'h1C;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
    // ------------
    // Field positions and reset values
    // ------------
    localparam int CTRL_START = 0;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    // ------------
    // Command codes, ranges, error codes
    // ------------
    localparam logic [15:0] CMD_APRD = 16'h0001;
    localparam logic [15:0] CMD_FPRD = 16'h0004;
    localparam logic [15:0] CMD_BRD = 16'h0007;
    localparam logic [15:0] LEN_MIN = 16'h0001;
    localparam logic [15:0] LEN_MAX = 16'h0004;
    localparam logic [15:0] APRD_FIRST = 16'h0000;
    localparam logic [15:0] APRD_LAST = 16'hFFDD;
    localparam logic [15:0] FPRD_FIRST = 16'h03E9;
    localparam logic [15:0] FPRD_LAST = 16'h040C;
    localparam logic [15:0] ERR_POS = 16'h0F60;
    localparam logic [15:0] ERR_LEN = 16'h0F61;
    localparam logic [15:0] ERR_CMD = 16'h0F62;
    localparam logic [15:0] ERR_NO_WKC = 16'h0F63;
    localparam logic [15:0] ERR_TIMEOUT = 16'h0F64;
    // ------------
    // Timing
    // ------------
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned TIMEOUT_US = 1000;
    localparam int unsigned TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
endpackage

// ---- fieldbus_ring_model.sv ----
// Behavioural ring of fieldbus slave controllers answering read datagrams.
// Assumes datagrams arrive as one-cycle pulses on clock_in, one at a time.
`timescale 1ns/1ps
`default_nettype none
module fieldbus_ring_model
    import fieldbus_reader_pkg::*;
#(
    parameter int unsigned N_SLAVES = 4
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic dgram_valid_in,
    input wire logic [15:0] dgram_cmd_in,
    input wire logic [15:0] dgram_pos_in,
    input wire logic [15:0] dgram_ofs_in,
    input wire logic [2:0] dgram_len_in,
    input wire logic [7:0] delay_in,
    input wire logic mute_in,
    output logic reply_valid_out,
    output logic [31:0] reply_data_out,
    output logic [15:0] reply_wkc_out
);
    // ------------
    // Slave contents and reply assembly
    // ------------
    logic hit;
    logic pending;
    logic [7:0] wait_cnt;
    logic [31:0] next_data, held_data, len_mask;
    logic [15:0] next_wkc, held_wkc;

    // Each slave holds a word made of the offset and its own index
    function automatic logic [31:0] slave_word(input logic [1:0] k, input logic [15:0] ofs);
        slave_word = {ofs, 8'h11 * ({6'h00, k} + 8'h01), 8'h01 << k};
    endfunction

    assign len_mask = (dgram_len_in >= 3'h4) ? 32'hFFFF_FFFF :
                      ((32'h0000_0001 << (8 * dgram_len_in)) - 32'h0000_0001);

    // Walk the ring; in auto-increment every slave sees the position bumped by those before it
    always_comb begin
        next_data = 32'h0000_0000;
        next_wkc = 16'h0000;
        for (int k = 0; k < N_SLAVES; k++) begin
            hit = 1'b0;
            case (dgram_cmd_in)
                CMD_APRD: hit = ((dgram_pos_in + 16'(k)) == 16'h0000);
                CMD_FPRD: hit = (dgram_pos_in == FPRD_FIRST + 16'(k));
                CMD_BRD: hit = 1'b1;
                default: hit = 1'b0;
            endcase
            if (hit) begin
                next_data = next_data | (slave_word(2'(k), dgram_ofs_in) & len_mask);
                next_wkc = next_wkc + 16'h0001;
            end
        end
    end

    // Reply after a chosen delay; released lines toggle so stale data never looks valid
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pending <= 1'b0;
            wait_cnt <= 8'h00;
            held_data <= 32'h0000_0000;
            held_wkc <= 16'h0000;
            reply_valid_out <= 1'b0;
            reply_data_out <= 32'h0000_0000;
            reply_wkc_out <= 16'h0000;
        end else begin
            reply_valid_out <= 1'b0;
            reply_data_out <= ~reply_data_out;
            reply_wkc_out <= ~reply_wkc_out;
            if (dgram_valid_in && !mute_in) begin
                pending <= 1'b1;
                wait_cnt <= delay_in;
                held_data <= next_data;
                held_wkc <= next_wkc;
            end else if (pending && wait_cnt == 8'h00) begin
                pending <= 1'b0;
                reply_valid_out <= 1'b1;
                reply_data_out <= held_data;
                reply_wkc_out <= held_wkc;
            end else if (pending) begin
                wait_cnt <= wait_cnt - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ---- fieldbus_slave_register_reader.sv ----
// Fieldbus slave register reader: register port, checks, datagram and reply.
// Assumes the ring returns at most one reply per datagram, synchronous to clock_in.
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fieldbus_slave_register_reader
    import fieldbus_reader_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    output logic irq_out,
    output logic busy_out,
    output logic done_out,
    output logic error_out,
    output logic [15:0] error_code_out,
    output logic [31:0] value_out,
    output logic [15:0] wkc_out,
    output logic dgram_valid_out,
    output logic [15:0] dgram_cmd_out,
    output logic [15:0] dgram_pos_out,
    output logic [15:0] dgram_ofs_out,
    output logic [2:0] dgram_len_out,
    input wire logic reply_valid_in,
    input wire logic [31:0] reply_data_in,
    input wire logic [15:0] reply_wkc_in
);
    // ------------
    // Helpers
    // ------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SEND = 3'h2,
        ST_WAIT = 3'h4
    } state_type;

    // Position check per command
    function automatic logic pos_ok(
        input logic [15:0] cmd,
        input logic [15:0] pos
    );
        logic ok;
        ok = 1'b0;
        case (cmd)
            CMD_APRD: ok = (pos == APRD_FIRST) || (pos >= APRD_LAST); // R7
            CMD_FPRD: ok = (pos >= FPRD_FIRST) && (pos <= FPRD_LAST); // R8
            CMD_BRD: ok = 1'b1; // R6
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // Keeps only the bytes that were asked for
    function automatic logic [31:0] byte_mask(input logic [2:0] len);
        logic [31:0] m;
        m = ZERO32;
        case (len)
            3'h1: m = 32'h0000_00FF;
            3'h2: m = 32'h0000_FFFF;
            3'h3: m = 32'h00FF_FFFF;
            3'h4: m = 32'hFFFF_FFFF;
            default: m = ZERO32;
        endcase
        return m;
    endfunction

    // ------------
    // State
    // ------------
    state_type st;
    logic start_lvl;
    logic start_prev;
    logic [15:0] pos_reg;
    logic [15:0] ofs_reg;
    logic [15:0] len_reg;
    logic [15:0] cmd_reg;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [15:0] run_cmd;
    logic [2:0] run_len;
    logic [31:0] tmo_cnt;

    // ------------
    // Decode
    // ------------
    wire wr_ctrl = wr_in && (addr_in == OFF_CTRL);
    wire wr_pos = wr_in && (addr_in == OFF_POS);
    wire wr_ofs = wr_in && (addr_in == OFF_OFS);
    wire wr_len = wr_in && (addr_in == OFF_LEN);
    wire wr_cmd = wr_in && (addr_in == OFF_CMD);
    wire wr_mask = wr_in && (addr_in == OFF_IRQ_MASK);
    wire rd_irq = rd_in && (addr_in == OFF_IRQ_STAT);

    // Edge of the start bit; a held level gives one pulse only
    wire start_fire = start_lvl && !start_prev; // R1
    wire accept = start_fire && (st == ST_IDLE);

    // Parameter checks, command first, then length, then position
    wire cmd_ok = (cmd_reg == CMD_APRD) || (cmd_reg == CMD_FPRD)
        || (cmd_reg == CMD_BRD); // R3
    wire len_ok = (len_reg >= LEN_MIN) && (len_reg <= LEN_MAX); // R2
    wire adr_ok = pos_ok(cmd_reg, pos_reg); // R5
    wire chk_fail = !cmd_ok || !len_ok || !adr_ok; // R18
    wire [15:0] chk_code = !cmd_ok ? ERR_CMD : // R4
        (!len_ok ? ERR_LEN : ERR_POS); // R2 R5

    // Reply handling; a reply outside a command is dropped
    wire reply_take = (st == ST_WAIT) && reply_valid_in;
    wire reply_good = reply_take && (reply_wkc_in != ZERO16); // R15
    wire tmo_hit = (st == ST_WAIT) && !reply_valid_in
        && (tmo_cnt >= TIMEOUT_CYCLES - 1);
    wire finish_err = (reply_take && !reply_good) || tmo_hit;
    wire [15:0] fail_code = tmo_hit ? ERR_TIMEOUT : ERR_NO_WKC;

    // Interrupt events; set beats the clear-on-read
    wire [1:0] irq_ev = {finish_err || (accept && chk_fail), reply_good};
    wire [1:0] next_irq_stat = (rd_irq ? 2'h0 : irq_stat) | irq_ev;

    // Read selection
    wire [31:0] stat_word = {error_code_out, 13'h0000,
        error_out, done_out, busy_out};
    wire [31:0] rd_sel =
        (addr_in == OFF_CTRL) ? {31'h0000_0000, start_lvl} :
        (addr_in == OFF_POS) ? {ZERO16, pos_reg} :
        (addr_in == OFF_OFS) ? {ZERO16, ofs_reg} :
        (addr_in == OFF_LEN) ? {ZERO16, len_reg} :
        (addr_in == OFF_CMD) ? {ZERO16, cmd_reg} :
        (addr_in == OFF_STAT) ? stat_word :
        (addr_in == OFF_VALUE) ? value_out :
        (addr_in == OFF_WKC) ? {ZERO16, wkc_out} :
        (addr_in == OFF_IRQ_STAT) ? {30'h0000_0000, irq_stat} :
        (addr_in == OFF_IRQ_MASK) ? {30'h0000_0000, irq_mask} :
        ZERO32;

    // ------------
    // Software registers
    // ------------
    // Parameters written by software
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            start_lvl <= 1'b0;
            start_prev <= 1'b0;
            pos_reg <= ZERO16;
            ofs_reg <= ZERO16;
            len_reg <= ZERO16;
            cmd_reg <= ZERO16;
            irq_mask <= 2'h0;
        end else begin
            start_prev <= start_lvl;
            if (wr_ctrl) start_lvl <= wdata_in[CTRL_START];
            if (wr_pos) pos_reg <= wdata_in[15:0];
            if (wr_ofs) ofs_reg <= wdata_in[15:0];
            if (wr_len) len_reg <= wdata_in[15:0];
            if (wr_cmd) cmd_reg <= wdata_in[15:0];
            if (wr_mask) irq_mask <= wdata_in[1:0];
        end
    end

    // Read data and interrupt, one cycle after the strobe
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= ZERO32;
            irq_stat <= 2'h0;
            irq_out <= 1'b0;
        end else begin
            rdata_out <= rd_in ? rd_sel : ZERO32;
            irq_stat <= next_irq_stat;
            irq_out <= |(next_irq_stat & irq_mask);
        end
    end

    // ------------
    // Sequencer
    // ------------
    // Parameters are frozen at acceptance so later writes cannot skew a read
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st <= ST_IDLE;
            run_cmd <= ZERO16;
            run_len <= 3'h0;
        end else begin
            case (st)
                ST_IDLE: begin
                    if (accept && !chk_fail) begin // R18
                        st <= ST_SEND;
                        run_cmd <= cmd_reg;
                        run_len <= len_reg[2:0];
                    end
                end
                ST_SEND: st <= ST_WAIT;
                ST_WAIT: begin
                    if (reply_take || tmo_hit) st <= ST_IDLE;
                end
                default: st <= ST_IDLE;
            endcase
        end
    end

    // Response timer; long waits on a broken ring end in an error
    // Cleared outside the wait, so each datagram gets the full span
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) tmo_cnt <= ZERO32;
        else if (st != ST_WAIT) tmo_cnt <= ZERO32;
        else tmo_cnt <= tmo_cnt + 32'h0000_0001;
    end

    // Datagram to the ring; broadcast sends position zero
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dgram_valid_out <= 1'b0;
            dgram_cmd_out <= ZERO16;
            dgram_pos_out <= ZERO16;
            dgram_ofs_out <= ZERO16;
            dgram_len_out <= 3'h0;
        end else begin
            dgram_valid_out <= (st == ST_SEND);
            if (st == ST_SEND) begin
                dgram_cmd_out <= run_cmd; // R3 R13
                dgram_len_out <= run_len;
            end
            if (accept && !chk_fail) begin
                dgram_pos_out <= (cmd_reg == CMD_BRD) ? ZERO16 : pos_reg; // R6
                dgram_ofs_out <= ofs_reg;
            end
        end
    end

    // Completion outputs
    // A zero working count means no slave read, so it ends in error
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_out <= 1'b0;
            done_out <= 1'b0;
            error_out <= 1'b0;
            error_code_out <= ZERO16;
            value_out <= ZERO32;
            wkc_out <= ZERO16;
        end else if (accept) begin
            value_out <= ZERO32; // R9
            wkc_out <= ZERO16; // R9
            done_out <= 1'b0;
            error_out <= chk_fail; // R17
            error_code_out <= chk_fail ? chk_code : ZERO16; // R17
            busy_out <= !chk_fail; // R16
        end else if (reply_good) begin
            busy_out <= 1'b0; // R19
            done_out <= 1'b1; // R15
            value_out <= reply_data_in & byte_mask(run_len); // R10 R13
            wkc_out <= reply_wkc_in; // R10 R14
        end else if (finish_err) begin
            busy_out <= 1'b0; // R19
            error_out <= 1'b1; // R17
            error_code_out <= fail_code;
            wkc_out <= reply_take ? reply_wkc_in : ZERO16;
        end
    end

    // ------------
    // Assertions
    // ------------
    sequence s_good_start;
        accept && !chk_fail;
    endsequence

    sequence s_good_reply;
        (st == ST_WAIT) && reply_valid_in && (reply_wkc_in != ZERO16);
    endsequence

    property p_edge_only;
        @(posedge clock_in) disable iff (!rst_n_in)
        $rose(busy_out) |-> $past(start_fire) && !$past(start_prev);
    endproperty
    a_edge_only: assert property (p_edge_only) // R1
        else $error("busy rose without a start edge");

    property p_len_err;
        @(posedge clock_in) disable iff (!rst_n_in)
        (accept && cmd_ok && !len_ok) |=>
            error_out && !busy_out && (error_code_out == ERR_LEN);
    endproperty
    a_len_err: assert property (p_len_err) // R2
        else $error("bad length not flagged");

    property p_cmd_err;
        @(posedge clock_in) disable iff (!rst_n_in)
        (accept && !cmd_ok) |=> error_out && (error_code_out == ERR_CMD);
    endproperty
    a_cmd_err: assert property (p_cmd_err) // R4
        else $error("bad command not flagged");

    property p_pos_err;
        @(posedge clock_in) disable iff (!rst_n_in)
        (accept && cmd_ok && len_ok && !adr_ok) |=>
            error_out && (error_code_out == ERR_POS);
    endproperty
    a_pos_err: assert property (p_pos_err) // R5
        else $error("bad position not flagged");

    property p_brd_any_pos;
        @(posedge clock_in) disable iff (!rst_n_in)
        (accept && (cmd_reg == CMD_BRD) && len_ok) |=> busy_out && !error_out;
    endproperty
    a_brd_any_pos: assert property (p_brd_any_pos) // R6
        else $error("broadcast read refused");

    property p_aprd_last;
        @(posedge clock_in) disable iff (!rst_n_in)
        (accept && (cmd_reg == CMD_APRD) && len_ok && (pos_reg == APRD_LAST))
            |=> busy_out;
    endproperty
    a_aprd_last: assert property (p_aprd_last) // R7
        else $error("last auto-increment position refused");

    property p_send_cmd;
        @(posedge clock_in) disable iff (!rst_n_in)
        s_good_start |=> ##1 dgram_valid_out && (dgram_cmd_out == $past(cmd_reg, 2))
            ##1 !dgram_valid_out;
    endproperty
    a_send_cmd: assert property (p_send_cmd) // R3
        else $error("datagram not sent once with the code");

    property p_clear;
        @(posedge clock_in) disable iff (!rst_n_in)
        accept |=> (value_out == ZERO32) && (wkc_out == ZERO16) && !done_out;
    endproperty
    a_clear: assert property (p_clear) // R9
        else $error("value or count not cleared at start");

    property p_done_value;
        @(posedge clock_in) disable iff (!rst_n_in)
        s_good_reply |=> done_out && (wkc_out == $past(reply_wkc_in))
            && (value_out == ($past(reply_data_in) & byte_mask(run_len)));
    endproperty
    a_done_value: assert property (p_done_value) // R10
        else $error("done without reply data");

    property p_done_cause;
        @(posedge clock_in) disable iff (!rst_n_in)
        $rose(done_out) |-> $past(st == ST_WAIT) && $past(reply_valid_in)
            && ($past(reply_wkc_in) != ZERO16);
    endproperty
    a_done_cause: assert property (p_done_cause) // R15
        else $error("done without a slave read");

    property p_no_send_on_fail;
        @(posedge clock_in) disable iff (!rst_n_in)
        (accept && chk_fail) |=> (!dgram_valid_out && !done_out) [*3];
    endproperty
    a_no_send_on_fail: assert property (p_no_send_on_fail) // R18
        else $error("datagram sent after failed check");

    property p_busy_end;
        @(posedge clock_in) disable iff (!rst_n_in)
        $fell(busy_out) |-> (done_out != error_out);
    endproperty
    a_busy_end: assert property (p_busy_end) // R19
        else $error("busy fell without one completion");

    property p_busy_hold;
        @(posedge clock_in) disable iff (!rst_n_in)
        s_good_start |=> busy_out [*3];
    endproperty
    a_busy_hold: assert property (p_busy_hold) // R16
        else $error("busy dropped before finish");
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the fieldbus slave register reader.
// Assumes the ring model stands on the datagram side, with four slaves.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import fieldbus_reader_pkg::*;
;
    // ------------
    // Signals, clock, instances
    // ------------
    logic clock_in, rst_n_in, wr, rd, irq, busy, done, err, dv, rv, mute;
    logic [7:0] addr, dly_sel;
    logic [31:0] wdata, rdata, value, rdat, rd_word;
    logic [15:0] code, wkc, dcmd, dpos, dofs, rwkc, cap_pos;
    logic [2:0] dlen, cap_len;
    int n_errors = 0;
    int checks_done = 0;
    int dgrams = 0, cycles = 0, held = 0;

    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end

    fieldbus_slave_register_reader #(.TIMEOUT_CYCLES(50)) i_dut (.clock_in(clock_in),
        .rst_n_in(rst_n_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .irq_out(irq), .busy_out(busy), .done_out(done),
        .error_out(err), .error_code_out(code), .value_out(value), .wkc_out(wkc),
        .dgram_valid_out(dv), .dgram_cmd_out(dcmd), .dgram_pos_out(dpos),
        .dgram_ofs_out(dofs), .dgram_len_out(dlen), .reply_valid_in(rv),
        .reply_data_in(rdat), .reply_wkc_in(rwkc));

    fieldbus_ring_model i_ring (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .dgram_valid_in(dv), .dgram_cmd_in(dcmd), .dgram_pos_in(dpos),
        .dgram_ofs_in(dofs), .dgram_len_in(dlen), .delay_in(dly_sel), .mute_in(mute),
        .reply_valid_out(rv), .reply_data_out(rdat), .reply_wkc_out(rwkc));

    // Count datagrams and keep the position and length of the last one; watchdog on hangs
    always @(posedge clock_in) begin
        cycles++;
        if (dv === 1'b1) begin
            dgrams++;
            cap_pos <= dpos;
            cap_len <= dlen;
        end
        if (cycles == 5000) begin
            n_errors++;
            $display("Error at %0t: run hung", $time);
            summarize();
        end
    end

    // ------------
    // Helpers
    // ------------
    function automatic logic [31:0] sw(input logic [1:0] k, input logic [15:0] ofs);
        sw = {ofs, 8'h11 * ({6'h00, k} + 8'h01), 8'h01 << k};
    endfunction

    function automatic logic [31:0] msk(input logic [2:0] n);
        msk = (n >= 3'h4) ? 32'hFFFF_FFFF : ((32'h0000_0001 << (8 * n)) - 32'h0000_0001);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Register port cycles: one-cycle strobes, read data in the next cycle only
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_in);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_in);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // One full command; the start bit is dropped first so a real edge is seen
    task automatic run(input logic [15:0] cmd, input logic [15:0] pos, input logic [15:0] ofs,
        input logic [2:0] len, input logic [7:0] dly, input logic [15:0] ecode,
        input logic [31:0] val, input logic [15:0] ewkc);
        int n0;
        logic sent;
        dly_sel <= dly;
        wr_reg(OFF_POS, {16'h0000, pos});
        wr_reg(OFF_OFS, {16'h0000, ofs});
        wr_reg(OFF_LEN, {29'h0000_0000, len});
        wr_reg(OFF_CMD, {16'h0000, cmd});
        wr_reg(OFF_CTRL, 32'h0000_0000);
        n0 = dgrams;
        wr_reg(OFF_CTRL, 32'h0000_0001);
        @(posedge clock_in);
        #1;
        if (busy === 1'b1) begin
            chk(value, 32'h0000_0000);
            chk({16'h0000, wkc}, 32'h0000_0000);
        end
        while (done !== 1'b1 && err !== 1'b1) @(posedge clock_in);
        #1;
        sent = !(ecode inside {ERR_POS, ERR_LEN, ERR_CMD});
        chk({16'h0000, code}, {16'h0000, ecode});
        chk({31'h0, err}, {31'h0, ecode != 16'h0000});
        chk({31'h0, done}, {31'h0, ecode == 16'h0000});
        chk({31'h0, busy}, 32'h0000_0000);
        chk(32'(dgrams - n0), {31'h0, sent});
        if (sent) begin
            chk(value, val);
            chk({16'h0000, wkc}, {16'h0000, ewkc});
            chk({16'h0000, cap_pos}, {16'h0000, (cmd == CMD_BRD) ? 16'h0000 : pos});
            chk({29'h0, cap_len}, {29'h0, len});
        end
    endtask

    task automatic summarize();
        if (n_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------
    // Main sequence
    // ------------
    initial begin
        rst_n_in = 1'b0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        wr = 1'b0;
        rd = 1'b0;
        mute = 1'b0;
        dly_sel = 8'h02;
        repeat (5) @(posedge clock_in);
        rst_n_in <= 1'b1;
        // Refused parameters, checked before anything is sent
        run(16'h0002, 16'h0000, 16'h0130, 3'h1, 8'h01, ERR_CMD, 0, 0);
        run(16'h0000, 16'h0000, 16'h0130, 3'h5, 8'h01, ERR_CMD, 0, 0);
        run(16'h0008, 16'h0000, 16'h0130, 3'h1, 8'h01, ERR_CMD, 0, 0);
        run(CMD_APRD, 16'h0000, 16'h0130, 3'h0, 8'h01, ERR_LEN, 0, 0);
        run(CMD_BRD, 16'h0000, 16'h0130, 3'h5, 8'h01, ERR_LEN, 0, 0);
        run(CMD_APRD, 16'hFFDC, 16'h0130, 3'h1, 8'h01, ERR_POS, 0, 0);
        run(CMD_APRD, 16'h0001, 16'h0130, 3'h1, 8'h01, ERR_POS, 0, 0);
        run(CMD_FPRD, 16'h03E8, 16'h0130, 3'h1, 8'h01, ERR_POS, 0, 0);
        run(CMD_FPRD, 16'h040D, 16'h0130, 3'h1, 8'h01, ERR_POS, 0, 0);
        rd_reg(OFF_STAT, rd_word);
        chk(rd_word, {ERR_POS, 16'h0004});
        // Interrupt raised, cleared by reading, then masked
        rd_reg(OFF_IRQ_STAT, rd_word);
        chk(rd_word, 32'h0000_0002);
        wr_reg(OFF_IRQ_MASK, 32'h0000_0003);
        run(CMD_APRD, 16'h0000, 16'h0130, 3'h4, 8'h03, 0, sw(0, 16'h0130), 1);
        @(posedge clock_in);
        #1;
        chk({31'h0, irq}, 32'h0000_0001);
        rd_reg(OFF_IRQ_STAT, rd_word);
        chk(rd_word, 32'h0000_0001);
        @(posedge clock_in);
        #1;
        chk({31'h0, irq}, 32'h0000_0000);
        wr_reg(OFF_IRQ_MASK, 32'h0000_0000);
        run(16'h0003, 16'h0000, 16'h0130, 3'h1, 8'h01, ERR_CMD, 0, 0);
        @(posedge clock_in);
        #1;
        chk({31'h0, irq}, 32'h0000_0000);
        rd_reg(OFF_IRQ_STAT, rd_word);
        chk(rd_word, 32'h0000_0002);
        rd_reg(8'h30, rd_word);
        chk(rd_word, 32'h0000_0000);
        // Every length on the first slave, then the ring positions
        for (int n = 1; n <= 4; n++) begin
            run(CMD_APRD, 16'h0000, 16'h0200, 3'(n), 8'h02, 0, sw(0, 16'h0200) & msk(3'(n)), 1);
        end
        rd_reg(OFF_STAT, rd_word);
        chk(rd_word, 32'h0000_0002);
        rd_reg(OFF_VALUE, rd_word);
        chk(rd_word, sw(0, 16'h0200));
        run(CMD_APRD, 16'hFFFF, 16'h0210, 3'h4, 8'h02, 0, sw(1, 16'h0210), 1);
        run(CMD_APRD, 16'hFFFD, 16'h0210, 3'h2, 8'h00, 0, sw(3, 16'h0210) & msk(3'h2), 1);
        run(CMD_APRD, 16'hFFDD, 16'h0210, 3'h1, 8'h02, ERR_NO_WKC, 0, 0);
        run(CMD_FPRD, 16'h03E9, 16'h0300, 3'h4, 8'h02, 0, sw(0, 16'h0300), 1);
        run(CMD_FPRD, 16'h03EC, 16'h0300, 3'h3, 8'h05, 0, sw(3, 16'h0300) & msk(3'h3), 1);
        run(CMD_FPRD, 16'h040C, 16'h0300, 3'h1, 8'h02, ERR_NO_WKC, 0, 0);
        // Broadcast ignores the position; slow reply keeps busy up for a while
        run(CMD_BRD, 16'h1234, 16'h0130, 3'h1, 8'h28, 0, 32'h0000_000F, 4);
        run(CMD_BRD, 16'hFFFF, 16'h0130, 3'h4, 8'h01, 0, 32'h0130_770F, 4);
        rd_reg(OFF_WKC, rd_word);
        chk(rd_word, 32'h0000_0004);
        // A held start level must not retrigger
        held = dgrams;
        wr_reg(OFF_CTRL, 32'h0000_0001);
        repeat (10) @(posedge clock_in);
        #1;
        chk(32'(dgrams - held), 32'h0000_0000);
        chk({31'h0, done}, 32'h0000_0001);
        chk({31'h0, busy}, 32'h0000_0000);
        // Silent ring ends in the timeout error
        mute <= 1'b1;
        run(CMD_FPRD, 16'h03E9, 16'h0130, 3'h1, 8'h01, ERR_TIMEOUT, 0, 0);
        mute <= 1'b0;
        summarize();
    end
endmodule
`default_nettype wire
